/* File: rtl/link_status_channel_enable_regs.sv */
// link_status_channel_enable_regs: status, channel enable and sync header
// mode registers behind an avalon-mm slave with waitrequest, plus a
// sticky event status with enables driving one level interrupt.
// assumes sysref and link signals come from logic on the same clock;
// the sync pin and both pll lock pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module link_status_channel_enable_regs (
  input  wire logic                                MCLK_I,             // core clock, 250 MHz
  input  wire logic                                RSTN_I,             // async reset, active low
  // avalon-mm slave
  input  wire logic [link_regs_pkg::ADDR_W-1:0]    AVS_ADDRESS_I,      // byte address
  input  wire logic                                AVS_READ_I,         // read request
  input  wire logic                                AVS_WRITE_I,        // write request
  input  wire logic [link_regs_pkg::BE_W-1:0]      AVS_BYTEENABLE_I,   // byte lanes
  input  wire logic [link_regs_pkg::DATA_W-1:0]    AVS_WRITEDATA_I,    // write data
  output logic      [link_regs_pkg::DATA_W-1:0]    AVS_READDATA_O,     // read data
  output logic                                     AVS_WAITREQUEST_O,  // stall
  // link side, same clock
  input  wire logic                                LINK_UP_I,          // link established
  input  wire logic                                LINK_ENABLE_I,      // serial_link_enable
  input  wire logic                                SYSREF_EVENT_I,     // sysref seen, pulse
  input  wire logic                                SYSREF_REALIGN_I,   // clock phase moved, pulse
  // pins, asynchronous
  input  wire logic                                SYNC_N_I,           // receiver sync request, low active
  input  wire logic                                SER_PLL_LOCK_I,     // serializer_pll_lock
  input  wire logic                                SAMP_PLL_LOCK_I,    // sampling_pll_lock
  // controls
  output logic      [link_regs_pkg::CH_COUNT-1:0]  CH_ENABLE_O,        // channels d..a
  output logic      [link_regs_pkg::SH_W-1:0]      SH_MODE_O,          // sync header mode
  output logic                                     SH_CRC_O,           // send crc-12 words
  output logic                                     SH_FEC_O,           // send fec words
  output logic                                     IRQ_O               // level interrupt
);
  import link_regs_pkg::*;

  // reset release
  logic rst_meta_q;  // first release stage
  logic rst_n_q;     // reset used everywhere else

  // async assert, two-stage release so no flop sees a runt edge
  // the pin filter and every register below use rst_n_q, never the pin
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // pin filter
  pin_sync_if #(.N(PIN_W)) pins ();  // raw and clean pin levels

  // one process drives the whole lane vector, so no bit has two drivers
  always_comb begin
    pins.raw           = '0;
    pins.raw[PIN_SYNC] = SYNC_N_I;
    pins.raw[PIN_SER]  = SER_PLL_LOCK_I;
    pins.raw[PIN_SMP]  = SAMP_PLL_LOCK_I;
  end

  pin_filter u_pin_filter (
    .clk_i   (MCLK_I),
    .rst_n_i (rst_n_q),
    .pins    (pins)
  );

  // bus decode helpers
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
    widen = {{(DATA_W-REG_W){1'b0}}, v};
  endfunction

  // bus handshake
  logic        req;      // any request pending
  logic        ack_q;    // answer cycle
  logic        ack_d;
  logic        wr_take;  // write takes effect this edge
  logic [REG_W-1:0] wbyte;  // low write byte, taken whatever the lanes; wr_take gates on lane 0
  logic        lane0;    // byte lane 0 enabled

  assign req     = AVS_READ_I | AVS_WRITE_I;
  assign lane0   = AVS_BYTEENABLE_I[0];
  assign wr_take = AVS_WRITE_I & ack_q & lane0;
  assign wbyte   = AVS_WRITEDATA_I[REG_W-1:0];

  // per-register write strobes; one decode shared by all of its users
  logic wr_status;   // write to link_status_flags
  logic wr_chan;     // write to channel_pair_enables
  logic wr_shm;      // write to sync_header_mode
  logic wr_irq_clr;  // write to the event clear register
  logic wr_irq_en;   // write to the event enable register

  always_comb begin
    wr_status  = wr_take && hit(AVS_ADDRESS_I, IDX_LINK_STATUS);
    wr_chan    = wr_take && hit(AVS_ADDRESS_I, IDX_CHAN_EN);
    wr_shm     = wr_take && hit(AVS_ADDRESS_I, IDX_SH_MODE);
    wr_irq_clr = wr_take && hit(AVS_ADDRESS_I, IDX_IRQ_CLEAR);
    wr_irq_en  = wr_take && hit(AVS_ADDRESS_I, IDX_IRQ_ENABLE);
  end

  // one wait cycle per access, then the answer; keeps read data registered
  always_comb begin
    ack_d = req & ~ack_q;
  end

  assign AVS_WAITREQUEST_O = req & ~ack_q;

  // register state
  logic             mf_set_q;     // multiframe_phase_set_flag
  logic             mf_set_d;
  logic             realign_q;    // clock phase shift flag
  logic             realign_d;
  logic             armed_q;      // waiting for first sysref after enable
  logic             armed_d;
  logic             link_en_q;    // previous serial_link_enable
  logic             link_up_q;    // previous link up, for the edge event
  logic [2:0]       chan_q;       // one_channel_select, upper, lower pair
  logic [2:0]       chan_d;
  logic [SH_W-1:0]  shm_q;        // sync_header_mode field
  logic [SH_W-1:0]  shm_d;
  logic [IRQ_W-1:0] irq_sts_q;    // sticky events
  logic [IRQ_W-1:0] irq_sts_d;
  logic [IRQ_W-1:0] irq_en_q;     // interrupt enables
  logic [IRQ_W-1:0] irq_en_d;
  logic [IRQ_W-1:0] events;       // this cycle's events
  logic             mf_event;     // multiframe phase established now
  logic             clr_realign;  // software clears realign flag
  logic             clr_mf;       // software clears multiframe flag

  // first sysref after the link is enabled establishes the phase
  always_comb begin
    armed_d  = armed_q;
    mf_event = 1'b0;
    if (LINK_ENABLE_I && !link_en_q) begin
      armed_d = 1'b1;
    end
    if (!LINK_ENABLE_I) begin
      armed_d = 1'b0;                          // disabling drops the wait
    end else if (SYSREF_EVENT_I && (armed_q || !link_en_q)) begin
      mf_event = 1'b1;
      armed_d  = 1'b0;
    end
  end

  // status flag updates; a clear only takes a written one
  always_comb begin
    clr_realign = wr_status && wbyte[ST_REALIGN];
    clr_mf      = wr_status && wbyte[ST_MF_SET];
    realign_d   = realign_q;
    mf_set_d    = mf_set_q;
    if (clr_realign) begin
      realign_d = 1'b0;
    end
    if (SYSREF_REALIGN_I) begin
      realign_d = 1'b1;
    end
    if (clr_mf) begin
      mf_set_d = 1'b0;
    end
    if (mf_event) begin
      mf_set_d = 1'b1;
    end
  end

  // writable configuration; reserved bits are never stored
  always_comb begin
    chan_d = chan_q;
    shm_d  = shm_q;
    if (wr_chan) begin
      chan_d = wbyte[2:0];
    end
    if (wr_shm) begin
      shm_d = wbyte[SH_W-1:0];
    end
  end

  // interrupt events, enables and w1c clear; a new event beats the clear
  // so an event landing on the clearing write is never lost
  always_comb begin
    events              = '0;
    events[EV_REALIGN]  = SYSREF_REALIGN_I;
    events[EV_MF_SET]   = mf_event;
    events[EV_LINK_UP]  = LINK_UP_I & ~link_up_q;
    irq_sts_d           = irq_sts_q;
    irq_en_d            = irq_en_q;
    if (wr_irq_clr) begin
      irq_sts_d = irq_sts_d & ~wbyte[IRQ_W-1:0];
    end
    irq_sts_d = irq_sts_d | events;
    if (wr_irq_en) begin
      irq_en_d = wbyte[IRQ_W-1:0];
    end
  end

  // live status byte; lock, link and sync bits are not storage, so writes
  // to them cannot change anything
  logic [REG_W-1:0] status_byte;
  always_comb begin
    status_byte              = RST_LINK_STATUS;
    status_byte[ST_LINK_UP]  = link_up_q;
    status_byte[ST_SYNC]     = pins.clean[PIN_SYNC];
    status_byte[ST_REALIGN]  = realign_q;
    status_byte[ST_MF_SET]   = mf_set_q;
    status_byte[ST_SER_LOCK] = pins.clean[PIN_SER];
    status_byte[ST_SMP_LOCK] = pins.clean[PIN_SMP];
  end

  // read mux; unmapped and write-only addresses read as zero
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (AVS_READ_I && !ack_q) begin
      rdata_d = '0;
      if (hit(AVS_ADDRESS_I, IDX_LINK_STATUS)) begin
        rdata_d = widen(status_byte);
      end else if (hit(AVS_ADDRESS_I, IDX_CHAN_EN)) begin
        rdata_d = widen({5'h00, chan_q});
      end else if (hit(AVS_ADDRESS_I, IDX_SH_MODE)) begin
        rdata_d = widen({{(REG_W-SH_W){1'b0}}, shm_q});
      end else if (hit(AVS_ADDRESS_I, IDX_IRQ_STATUS)) begin
        rdata_d = widen({{(REG_W-IRQ_W){1'b0}}, irq_sts_q});
      end else if (hit(AVS_ADDRESS_I, IDX_IRQ_ENABLE)) begin
        rdata_d = widen({{(REG_W-IRQ_W){1'b0}}, irq_en_q});
      end
    end
  end

  // channel and sync word decode; reserved modes send neither word kind
  // one channel mode forces channels b..d off; clearing the lower pair
  // there turns every channel off, which software must not do
  logic [CH_COUNT-1:0] ch_d;
  logic [CH_COUNT-1:0] ch_q;
  logic                crc_d;
  logic                crc_q;
  logic                fec_d;
  logic                fec_q;
  logic                irq_d;
  logic                irq_q;
  always_comb begin
    ch_d[0] = chan_q[CE_LOWER_PAIR];
    ch_d[1] = chan_q[CE_LOWER_PAIR] & ~chan_q[CE_ONE_CHANNEL];
    ch_d[2] = chan_q[CE_UPPER_PAIR] & ~chan_q[CE_ONE_CHANNEL];
    ch_d[3] = chan_q[CE_UPPER_PAIR] & ~chan_q[CE_ONE_CHANNEL];
    crc_d   = (shm_q == SH_CRC12);
    fec_d   = (shm_q == SH_FEC);
    irq_d   = |(irq_sts_q & irq_en_q);
  end

  // all state registers; configuration changes are assumed to happen with
  // the link and calibration stopped, so no shadowing is done here
  always_ff @(posedge MCLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q     <= 1'b0;
      realign_q <= 1'b0;
      mf_set_q  <= 1'b0;
      armed_q   <= 1'b0;
      link_en_q <= 1'b0;
      link_up_q <= 1'b0;
      chan_q    <= RST_CHAN_EN;
      shm_q     <= RST_SH_MODE;
      irq_sts_q <= RST_IRQ;
      irq_en_q  <= RST_IRQ;
      rdata_q   <= '0;
      ch_q      <= '0;
      crc_q     <= 1'b0;
      fec_q     <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      ack_q     <= ack_d;
      realign_q <= realign_d;
      mf_set_q  <= mf_set_d;
      armed_q   <= armed_d;
      link_en_q <= LINK_ENABLE_I;
      link_up_q <= LINK_UP_I;
      chan_q    <= chan_d;
      shm_q     <= shm_d;
      irq_sts_q <= irq_sts_d;
      irq_en_q  <= irq_en_d;
      rdata_q   <= rdata_d;
      ch_q      <= ch_d;
      crc_q     <= crc_d;
      fec_q     <= fec_d;
      irq_q     <= irq_d;
    end
  end

  // outputs
  assign AVS_READDATA_O = rdata_q;
  assign CH_ENABLE_O    = ch_q;
  assign SH_MODE_O      = shm_q;
  assign SH_CRC_O       = crc_q;
  assign SH_FEC_O       = fec_q;
  assign IRQ_O          = irq_q;

endmodule : link_status_channel_enable_regs

`default_nettype wire

/* File: rtl/link_regs_pkg.sv */
// link_regs_pkg: offsets, field positions, reset values and codes for the
// link status / channel enable register bank.
// assumes a 32-bit avalon-mm slave, one 32-bit bus word per register index.

package link_regs_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;  // byte address width
  localparam int unsigned DATA_W = 32;  // bus data width
  localparam int unsigned BE_W   = 4;   // byte enable width
  localparam int unsigned REG_W  = 8;   // width of each register

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_LINK_STATUS = 12'h208;  // link_status_flags
  localparam logic [ADDR_W-1:0] IDX_CHAN_EN     = 12'h209;  // channel_pair_enables
  localparam logic [ADDR_W-1:0] IDX_SH_MODE     = 12'h20f;  // sync_header_mode
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS  = 12'h220;  // sticky event bits, read only
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR   = 12'h221;  // write one to clear, reads zero
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE  = 12'h222;  // interrupt enables

  // link_status_flags fields
  localparam int unsigned ST_LINK_UP  = 6;
  localparam int unsigned ST_SYNC     = 5;
  localparam int unsigned ST_REALIGN  = 4;
  localparam int unsigned ST_MF_SET   = 3;
  localparam int unsigned ST_SER_LOCK = 2;
  localparam int unsigned ST_SMP_LOCK = 0;
  localparam logic [REG_W-1:0] RST_LINK_STATUS = 8'h00;

  // channel_pair_enables fields
  localparam int unsigned CE_ONE_CHANNEL = 2;
  localparam int unsigned CE_UPPER_PAIR  = 1;
  localparam int unsigned CE_LOWER_PAIR  = 0;
  localparam logic [2:0]  RST_CHAN_EN    = 3'h3;

  // sync_header_mode field and codes
  localparam int unsigned SH_W         = 2;
  localparam logic [SH_W-1:0] RST_SH_MODE = 2'h0;
  localparam logic [SH_W-1:0] SH_CRC12    = 2'h0;
  localparam logic [SH_W-1:0] SH_FEC      = 2'h2;

  // interrupt event bits
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned EV_REALIGN  = 0;
  localparam int unsigned EV_MF_SET   = 1;
  localparam int unsigned EV_LINK_UP  = 2;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

  // pin synchroniser lanes and channel count
  localparam int unsigned PIN_W     = 3;
  localparam int unsigned PIN_SYNC  = 0;
  localparam int unsigned PIN_SER   = 1;
  localparam int unsigned PIN_SMP   = 2;
  localparam int unsigned CH_COUNT  = 4;

endpackage : link_regs_pkg

/* File: rtl/pin_sync_if.sv */
// pin_sync_if: raw pin levels in, filtered levels out, between the
// register bank and its pin filter.
// assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(
  parameter int unsigned N = 3
);
  logic [N-1:0] raw;    // levels straight from the pins
  logic [N-1:0] clean;  // levels after agreement filtering

  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : pin_sync_if

`default_nettype wire

/* File: rtl/pin_filter.sv */
// pin_filter: three-stage synchroniser per lane with an agreement filter.
// assumes an active-low reset already released synchronously.
`timescale 1ns/1ps
`default_nettype none

module pin_filter (
  input  wire logic clk_i,    // core clock
  input  wire logic rst_n_i,  // synchronised reset, active low
  pin_sync_if.filt  pins      // raw in, clean out
);
  import link_regs_pkg::*;

  logic [PIN_W-1:0] meta_q;   // first stage, read only by second stage
  logic [PIN_W-1:0] stage2_q; // second stage
  logic [PIN_W-1:0] stage3_q; // third stage
  logic [PIN_W-1:0] clean_q;  // accepted level
  logic [PIN_W-1:0] clean_d;

  // a lane changes only once stages two and three agree, so one bad
  // sample near a pin edge never reaches the status bits
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      clean_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : clean_q[i];
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q   <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      clean_q  <= '0;
    end else begin
      meta_q   <= pins.raw;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
      clean_q  <= clean_d;
    end
  end

  assign pins.clean = clean_q;
endmodule : pin_filter

`default_nettype wire

/* File: testbench/link_regs_assertions.sv */
// link_regs_assertions: bus handshake, channel enable and mode output checks.
// assumes it is bound to the register bank top; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module link_regs_assertions (
  input wire logic        MCLK_I,            // core clock
  input wire logic        RSTN_I,            // raw reset, active low
  input wire logic [11:0] AVS_ADDRESS_I,     // byte address
  input wire logic        AVS_READ_I,        // read request
  input wire logic        AVS_WRITE_I,       // write request
  input wire logic [3:0]  AVS_BYTEENABLE_I,  // byte lanes
  input wire logic [31:0] AVS_WRITEDATA_I,   // write data
  input wire logic [31:0] AVS_READDATA_O,    // read data
  input wire logic        AVS_WAITREQUEST_O, // stall
  input wire logic        LINK_UP_I,         // link established
  input wire logic [3:0]  CH_ENABLE_O,       // channels d..a
  input wire logic [1:0]  SH_MODE_O,         // stored mode
  input wire logic        SH_CRC_O,          // crc words
  input wire logic        SH_FEC_O           // fec words
);
  logic [2:0] up_q, up_d;    // edges since release, saturating
  logic [3:0] map_q, map_d;  // channel map expected from last write
  logic       wr_ch, rd_ok;  // accepted channel write, finished read

  assign wr_ch = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 12'h824 && AVS_BYTEENABLE_I[0];
  assign rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;

  // next values; the count hides the two-flop reset release lag
  always_comb begin
    up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    map_d = map_q;
    if (wr_ch) begin
      map_d = {{2{AVS_WRITEDATA_I[1] & ~AVS_WRITEDATA_I[2]}},
               AVS_WRITEDATA_I[0] & ~AVS_WRITEDATA_I[2], AVS_WRITEDATA_I[0]};
    end
  end

  // helper registers
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      up_q  <= 3'h0;
      map_q <= 4'hf;
    end else begin
      up_q  <= up_d;
      map_q <= map_d;
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  a_wait_first: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O)
    else $error("no wait cycle on a new request");
  a_wait_one: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("wait longer than one cycle");
  a_ch_map: assert property (wr_ch |=> ##1 CH_ENABLE_O == map_q)
    else $error("channel enables do not match written pairs");
  a_ch_hold: assert property ($changed(CH_ENABLE_O) && up_q == 3'h7 |-> $past(wr_ch) || $past(wr_ch, 2))
    else $error("channel enables moved without a write");
  a_crc_mode: assert property ($stable(SH_MODE_O) && up_q == 3'h7 |-> SH_CRC_O == (SH_MODE_O == 2'h0))
    else $error("crc select wrong");
  a_fec_mode: assert property ($stable(SH_MODE_O) && up_q == 3'h7 |-> SH_FEC_O == (SH_MODE_O == 2'h2))
    else $error("fec select wrong");
  a_link_read: assert property (rd_ok && AVS_ADDRESS_I == 12'h820 && $stable(LINK_UP_I)
      && $past(LINK_UP_I) == $past(LINK_UP_I, 2) && $past(LINK_UP_I, 2) == $past(LINK_UP_I, 3)
      |-> AVS_READDATA_O[6] == LINK_UP_I)
    else $error("link flag read wrong");
  a_rsvd_zero: assert property (rd_ok |-> AVS_READDATA_O[31:8] == 24'h0
      && !(AVS_ADDRESS_I == 12'h820 && (AVS_READDATA_O[7] || AVS_READDATA_O[1]))
      && !(AVS_ADDRESS_I == 12'h824 && AVS_READDATA_O[7:3] != 5'h0))
    else $error("reserved read bits not zero");
  a_unmapped_zero: assert property (rd_ok && !(AVS_ADDRESS_I inside {12'h820, 12'h824, 12'h83c,
      12'h880, 12'h888}) |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");
endmodule : link_regs_assertions

`default_nettype wire

/* File: testbench/link_far_end.sv */
// link_far_end: receiver model; holds sync low while idle, answers a link
// request after lag_i cycles. assumes the bench's core clock.
`timescale 1ns/1ps
`default_nettype none

module link_far_end (
  input  wire logic       clk_i,     // core clock
  input  wire logic       go_i,      // bring the link up
  input  wire logic [3:0] lag_i,     // answer delay, prompt or slow
  output logic            sync_n_o,  // sync request, low active
  output logic            link_up_o  // link established
);
  int cnt = 0;  // cycles since the request

  initial begin
    sync_n_o = 1'b0;
    link_up_o = 1'b0;
  end

  // sync stays asserted until the lag runs out, then link follows
  always @(posedge clk_i) begin
    if (!go_i) begin
      cnt <= 0;
      sync_n_o <= 1'b0;  // request sync while idle
      link_up_o <= 1'b0;
    end else begin
      if (cnt < int'(lag_i)) cnt <= cnt + 1;
      sync_n_o <= (cnt >= int'(lag_i));
      link_up_o <= sync_n_o;
    end
  end
endmodule : link_far_end

`default_nettype wire

/* File: testbench/tb.sv */
// tb: drives the avalon-mm slave and link inputs, compares with an integer
// register model. assumes link_far_end as the receiver.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [11:0] A_ST = 12'h820, A_CH = 12'h824, A_SH = 12'h83c;
  localparam logic [11:0] A_IS = 12'h880, A_IC = 12'h884, A_IE = 12'h888;
  logic        clk = 1'b0, rst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, wrq, irq, crc, fec;
  logic [11:0] adr = 12'h0;
  logic [3:0]  be = 4'h0, lag = 4'h2, channel_pair_enables;
  logic [31:0] wd = 32'h0, rdat, seed = 32'h8a01, junk;
  logic        link_en = 1'b0, sysref = 1'b0, realign = 1'b0, ser = 1'b0, smp = 1'b0;
  logic        go = 1'b0, sync_n, link_up;
  logic [1:0]  sh_mode;
  int fails = 0, checks = 0, cyc = 0;
  int m_ch = 3, m_sh = 0, m_fl = 0, m_irq = 0, m_en = 0, m_lnk = 0;

  always #2 clk = ~clk;  // 250 MHz

  link_status_channel_enable_regs i_link_status_channel_enable_regs (
    .MCLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s),
    .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq),
    .LINK_UP_I(link_up), .LINK_ENABLE_I(link_en), .SYSREF_EVENT_I(sysref), .SYSREF_REALIGN_I(realign),
    .SYNC_N_I(sync_n), .SER_PLL_LOCK_I(ser), .SAMP_PLL_LOCK_I(smp), .CH_ENABLE_O(channel_pair_enables),
    .SH_MODE_O(sh_mode), .SH_CRC_O(crc), .SH_FEC_O(fec), .IRQ_O(irq));

  link_far_end i_link_far_end (.clk_i(clk), .go_i(go), .lag_i(lag), .sync_n_o(sync_n), .link_up_o(link_up));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one access; entered just after an edge, holds until waitrequest is low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    adr <= a;
    wd <= d;
    be <= b;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
    end while (wrq !== 1'b0);  // only the hang guard ends a stuck wait
    q = rdat;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    @(posedge clk);  // idle edge so strobes never change twice in a step
  endtask

  task automatic wr(input logic [11:0] a, input int d);
    logic [31:0] q;
    bus(1'b1, a, 32'(d), 4'h1, q);
  endtask

  task automatic rd(input logic [11:0] a, input int exp, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h1, q);
    chk(nm, q, 32'(exp));
  endtask

  function automatic int st_exp();
    return (m_lnk << 6) | (m_lnk << 5) | m_fl | (int'(ser) << 2) | int'(smp);
  endfunction

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_ST, 0, "status reset");
    rd(A_CH, 3, "chan reset");
    rd(A_SH, 0, "mode reset");
    chk("channel_pair_enables reset", 32'(channel_pair_enables), 32'hf);
    $display("test reset done");
    // link and calibration stay off while enables change
    for (int v = 0; v < 9; v++) begin
      m_ch = (v == 8) ? 3 : v; // both pairs, all four channels, last
      if (m_ch[2] && !m_ch[0]) continue; // lower pair kept set in one channel mode
      wr(A_CH, m_ch);
      bus(1'b1, A_CH, 32'h4, 4'h0, junk); // lane off, ignored
      rd(A_CH, m_ch, "chan");
      chk("channel_pair_enables", 32'(channel_pair_enables), {28'h0, {2{m_ch[1] & ~m_ch[2]}}, m_ch[0] & ~m_ch[2], m_ch[0]});
    end
    $display("test channels done");
    for (int m = 0; m < 4; m++) begin
      wr(A_SH, m); // link off
      rd(A_SH, m, "mode");
      chk("crc fec", {30'h0, crc, fec}, {30'h0, m == 0, m == 2});
      chk("sh_mode", 32'(sh_mode), 32'(m));
    end
    $display("test modes done");
    repeat (4) begin
      seed = xs();
      ser <= seed[0];
      smp <= seed[1];
      repeat (8) @(posedge clk);
      wr(A_ST, 32'hef); // read-only bits ignore writes
      rd(A_ST, st_exp(), "locks");
    end
    $display("test locks done");
    lag <= seed[5:2];
    go <= 1'b1;
    repeat (30) @(posedge clk);
    m_lnk = 1;
    m_irq = 4;
    rd(A_ST, st_exp(), "link up");
    chk("irq masked", 32'(irq), 32'h0);
    wr(A_IE, 7);
    @(posedge clk);  // registered interrupt follows the enable one edge later
    chk("irq on", 32'(irq), 32'h1);
    link_en <= 1'b1;
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
    realign <= 1'b1;
    @(posedge clk);
    realign <= 1'b0;
    repeat (2) @(posedge clk);
    m_fl = 24;
    rd(A_ST, st_exp(), "multiframe_phase_set_flag");
    m_irq = m_irq | 3;  // realign and phase set joined the link-up event
    rd(A_IS, m_irq, "irq status");
    wr(A_ST, 0);
    rd(A_ST, st_exp(), "zero write");
    wr(A_ST, 8);
    m_fl = 16;
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
    @(posedge clk);
    rd(A_ST, st_exp(), "clear mf");
    fork
      wr(A_ST, 16);
      begin
        @(posedge clk);
        realign <= 1'b1;
        @(posedge clk);
        realign <= 1'b0;
      end
    join
    rd(A_ST, st_exp(), "event wins");
    wr(A_ST, 16);
    m_fl = 0;
    rd(A_ST, st_exp(), "clear realign");
    wr(A_IC, 7);
    rd(A_IS, 0, "irq cleared");
    chk("irq off", 32'(irq), 32'h0);
    rd(12'h900, 0, "unmapped");
    rd(12'h821, 0, "misaligned");
    $display("test events done");
    end_of_test();
  end
endmodule : tb

bind link_status_channel_enable_regs link_regs_assertions i_link_regs_assertions (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LINK_UP_I(LINK_UP_I),
  .CH_ENABLE_O(CH_ENABLE_O), .SH_MODE_O(SH_MODE_O), .SH_CRC_O(SH_CRC_O), .SH_FEC_O(SH_FEC_O));

`default_nettype wire
